/* File: sfr_defs.svh */
// Purpose: Constants for the sample FIFO readout block
// Assumes: Included by bare name wherever a constant is needed
// Notes:   Offsets are byte register addresses on the serial port
//
// What this block does
// - Circular store of at most 32 samples
// - Three bytes per active channel per sample
// - Data register returns oldest unread sample bytes
// - Burst reads of 0x07 keep address fixed
// - Other registers advance address each byte
// - Address pointer sticks at 0xFF
// - Read index advances on sample's first byte
// - Write index advances per stored sample
// - Results left-justified, MSB at bit 17
// - Triplet bytes carry 17:16, 15:8, 7:0
// - Two-channel mode sample is two triplets
// - Registers 0x04 to 0x06 readable and writable, 0x07 read-only
// - Proximity transitions empty the buffer
// - Undervoltage clears write and read indices
// - Lost samples counted, saturate 0xF, cleared
// - Wrap-on-full overwrites, else storing stops
// - Near-full when empty slots equal level
// - New-sample flag set on store, read-cleared
`ifndef SFR_DEFS_SVH
`define SFR_DEFS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define SFR_ADDR_STAT   8'h00
`define SFR_ADDR_WIDX   8'h04
`define SFR_ADDR_LOST   8'h05
`define SFR_ADDR_RIDX   8'h06
`define SFR_ADDR_DATA   8'h07
`define SFR_ADDR_TOP    8'hff

// ----------------------------------------------------------------
// Fields and sizes
// ----------------------------------------------------------------
`define SFR_STAT_NFULL_BIT  7
`define SFR_STAT_NEWS_BIT   6
`define SFR_DEPTH           6'h20
`define SFR_LOST_MAX        5'h0f
`define SFR_BYTES_ONE       3'h3
`define SFR_BYTES_TWO       3'h6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SFR_RST_IDX     5'h00
`define SFR_RST_PTR     8'h00

`endif

/* File: sfr_pkg.sv */
// Purpose: Types shared by the sample FIFO readout block
// Assumes: Nothing
// Notes:   Constants live in sfr_defs.svh
package sfr_pkg;
    typedef enum logic [1:0] {
        SFR_OP_ADDR = 2'b00,
        SFR_OP_WR   = 2'b01,
        SFR_OP_RD   = 2'b10
    } sfr_op_t;
endpackage

/* File: sfr_sync.sv */
// Purpose: Two-flop level synchroniser
// Assumes: d_i is asynchronous to clk_i
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module sfr_sync (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_ff;
    logic sync_ff;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= d_i;
            sync_ff <= meta_ff;
        end
    end

    assign q_o = sync_ff;
endmodule

/* File: sfr_top.sv */
// Purpose: 32-entry sample FIFO read out through a byte register port
// Assumes: Link requests arrive on link_clk_i, samples on clk_i
// Notes:   Link and core meet through a toggle request/acknowledge
`timescale 1ns/1ps
`include "sfr_defs.svh"
module sfr_top (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        link_clk_i,
    input  wire logic        lk_addr_i,
    input  wire logic        lk_wr_i,
    input  wire logic        lk_rd_i,
    input  wire logic [7:0]  lk_wdata_i,
    output logic      [7:0]  lk_rdata_o,
    output logic             lk_done_o,
    output logic             lk_busy_o,
    input  wire logic        smp_valid_i,
    input  wire logic [17:0] smp_ch1_i,
    input  wire logic [17:0] smp_ch2_i,
    input  wire logic [1:0]  adc_res_i,
    input  wire logic        two_chan_i,
    input  wire logic        prox_mode_i,
    input  wire logic        proximity_irq_enable_i,
    input  wire logic        wrap_on_full_i,
    input  wire logic [3:0]  near_full_level_i,
    input  wire logic        uvlo_i,
    output logic             near_full_o,
    output logic             new_sample_flag_o
);
    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Resolution code 0..3 means 18..15 bits, right-justified input
    function automatic logic [17:0] ljust(input logic [17:0] s,
                                          input logic [1:0]  res);
        ljust = s << res;
    endfunction

    function automatic logic [7:0] fmt_byte(input logic [17:0] s,
                                            input logic [1:0]  pos);
        logic [7:0] b;
        b = 8'h00;
        unique case (pos)
            2'h0: b = {6'h00, s[17:16]};
            2'h1: b = s[15:8];
            2'h2: b = s[7:0];
            default: b = 8'h00;
        endcase
        fmt_byte = b;
    endfunction

    // ------------------------------------------------------------
    // Link domain: take a request, wait for the core to answer
    // ------------------------------------------------------------
    sfr_pkg::sfr_op_t lk_op_ff;
    logic [7:0]       lk_dat_ff;
    logic             lk_req_tgl_ff;
    logic             lk_ack_seen_ff;
    logic             lk_busy_ff;
    logic             lk_done_ff;
    logic [7:0]       lk_rdata_ff;
    logic             ack_s;
    logic             ack_tgl_ff;
    logic [7:0]       rdata_ff;

    wire lk_take   = !lk_busy_ff && (lk_addr_i || lk_wr_i || lk_rd_i);
    wire lk_ack_ev = lk_busy_ff && (ack_s ^ lk_ack_seen_ff);
    sfr_pkg::sfr_op_t nxt_lk_op;
    assign nxt_lk_op = lk_addr_i ? sfr_pkg::SFR_OP_ADDR :
                       lk_wr_i   ? sfr_pkg::SFR_OP_WR : sfr_pkg::SFR_OP_RD;

    sfr_sync u_ack_sync (
        .clk_i  (link_clk_i),
        .nrst_i (nrst_i),
        .d_i    (ack_tgl_ff),
        .q_o    (ack_s)
    );

    always_ff @(posedge link_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lk_op_ff       <= sfr_pkg::SFR_OP_ADDR;
            lk_dat_ff      <= 8'h00;
            lk_req_tgl_ff  <= 1'b0;
            lk_ack_seen_ff <= 1'b0;
            lk_busy_ff     <= 1'b0;
            lk_done_ff     <= 1'b0;
            lk_rdata_ff    <= 8'h00;
        end else begin
            lk_ack_seen_ff <= ack_s;
            lk_done_ff     <= lk_ack_ev;
            if (lk_take) begin
                lk_op_ff      <= nxt_lk_op;
                lk_dat_ff     <= lk_wdata_i;
                lk_req_tgl_ff <= !lk_req_tgl_ff;
                lk_busy_ff    <= 1'b1;
            end else if (lk_ack_ev) begin
                lk_busy_ff    <= 1'b0;
            end
            // Core holds rdata_ff still until the next request
            if (lk_ack_ev) begin
                lk_rdata_ff <= rdata_ff;
            end
        end
    end

    assign lk_busy_o  = lk_busy_ff;
    assign lk_done_o  = lk_done_ff;
    assign lk_rdata_o = lk_rdata_ff;

    // ------------------------------------------------------------
    // Core domain state
    // ------------------------------------------------------------
    logic             req_s;
    logic             uv_s;
    logic             req_seen_ff;
    logic [4:0]       wr_ff;
    logic [4:0]       rd_ff;
    logic [4:0]       lc_ff;
    logic             full_ff;
    logic [7:0]       ptr_ff;
    logic [2:0]       bidx_ff;
    logic [4:0]       slot_ff;
    logic             prox_q_ff;
    logic             nfull_ff;
    logic             news_ff;
    logic [35:0]      mem_ff [0:31];

    sfr_sync u_req_sync (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    (lk_req_tgl_ff),
        .q_o    (req_s)
    );

    sfr_sync u_uv_sync (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    (uvlo_i),
        .q_o    (uv_s)
    );

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    wire go     = req_s ^ req_seen_ff;
    wire op_adr = go && (lk_op_ff == sfr_pkg::SFR_OP_ADDR);
    wire op_wr  = go && (lk_op_ff == sfr_pkg::SFR_OP_WR);
    wire op_rd  = go && (lk_op_ff == sfr_pkg::SFR_OP_RD);
    wire rd07   = op_rd && (ptr_ff == `SFR_ADDR_DATA);
    wire stat_rd = op_rd && (ptr_ff == `SFR_ADDR_STAT);
    wire w_set  = op_wr && (ptr_ff == `SFR_ADDR_WIDX);
    wire r_set  = op_wr && (ptr_ff == `SFR_ADDR_RIDX);
    wire lc_set = op_wr && (ptr_ff == `SFR_ADDR_LOST);
    wire ptr_stay = (ptr_ff == `SFR_ADDR_DATA) || (ptr_ff == `SFR_ADDR_TOP);

    // ------------------------------------------------------------
    // Index and occupancy
    // ------------------------------------------------------------
    wire       empty    = !full_ff && (wr_ff == rd_ff);
    wire       prox_clr = proximity_irq_enable_i
                          && (prox_mode_i ^ prox_q_ff);
    wire       pop      = rd07 && (bidx_ff == 3'h0) && !empty;
    wire       store    = smp_valid_i && !uv_s
                          && (!full_ff || wrap_on_full_i);
    wire       lost     = smp_valid_i && !uv_s && full_ff;
    wire       roll     = store && full_ff;
    wire [4:0] wr_inc   = 5'(wr_ff + 5'h01);
    wire [4:0] rd_inc   = 5'(rd_ff + 5'h01);

    wire [4:0] nxt_wr = uv_s  ? `SFR_RST_IDX :
                        w_set ? lk_dat_ff[4:0] :
                        store ? wr_inc : wr_ff;
    // Host rewind is how a sample is read a second time
    wire [4:0] nxt_rd = uv_s     ? `SFR_RST_IDX :
                        r_set    ? lk_dat_ff[4:0] :
                        prox_clr ? nxt_wr :
                        (pop || roll) ? rd_inc : rd_ff;
    wire       nxt_full = (uv_s || w_set || r_set || prox_clr) ? 1'b0 :
                          pop   ? roll :
                          store ? (full_ff || (wr_inc == rd_ff)) :
                          full_ff;
    wire [5:0] nxt_unread = nxt_full ? `SFR_DEPTH
                                     : {1'b0, 5'(nxt_wr - nxt_rd)};
    wire       nf_hit = store && (6'(`SFR_DEPTH - nxt_unread)
                                  == {2'h0, near_full_level_i});
    // Loss in the same cycle as a pop still counts as one
    wire [4:0] nxt_lc = uv_s   ? `SFR_RST_IDX :
                        lc_set ? lk_dat_ff[4:0] :
                        pop    ? {4'h0, lost} :
                        (lost && lc_ff != `SFR_LOST_MAX)
                               ? 5'(lc_ff + 5'h01) : lc_ff;

    // ------------------------------------------------------------
    // Address pointer and byte position
    // ------------------------------------------------------------
    wire [2:0] nbytes = two_chan_i ? `SFR_BYTES_TWO
                                   : `SFR_BYTES_ONE;
    wire [2:0] bidx_inc = 3'(bidx_ff + 3'h1);
    wire [7:0] nxt_ptr = op_adr ? lk_dat_ff :
                         ((op_rd || op_wr) && !ptr_stay)
                             ? 8'(ptr_ff + 8'h01) : ptr_ff;
    wire [2:0] nxt_bidx = op_adr ? 3'h0 :
                          rd07   ? ((bidx_inc == nbytes) ? 3'h0
                                                         : bidx_inc)
                                 : bidx_ff;

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------
    wire [4:0]  rsel    = (bidx_ff == 3'h0) ? rd_ff : slot_ff;
    wire [35:0] rsmp    = mem_ff[rsel];
    wire        hi_trip = (bidx_ff >= `SFR_BYTES_ONE);
    wire [17:0] rchan   = hi_trip ? rsmp[35:18] : rsmp[17:0];
    wire [2:0]  rpos    = hi_trip ? 3'(bidx_ff - `SFR_BYTES_ONE)
                                  : bidx_ff;
    wire [7:0]  data_b  = fmt_byte(rchan, rpos[1:0]);
    wire [7:0]  stat_b  = (8'(nfull_ff) << `SFR_STAT_NFULL_BIT)
                        | (8'(news_ff) << `SFR_STAT_NEWS_BIT);
    // Registers beyond this block read as zero, so does the top slot
    wire [7:0]  rbyte =
        (ptr_ff == `SFR_ADDR_STAT) ? stat_b :
        (ptr_ff == `SFR_ADDR_WIDX) ? {3'h0, wr_ff} :
        (ptr_ff == `SFR_ADDR_LOST) ? {3'h0, lc_ff} :
        (ptr_ff == `SFR_ADDR_RIDX) ? {3'h0, rd_ff} :
        (ptr_ff == `SFR_ADDR_DATA) ? data_b : 8'h00;

    wire nxt_news  = store || (news_ff && !(stat_rd || rd07));
    wire nxt_nfull = nf_hit || (nfull_ff && !stat_rd);

    // ------------------------------------------------------------
    // Core registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            req_seen_ff <= 1'b0;
            ack_tgl_ff  <= 1'b0;
            rdata_ff    <= 8'h00;
            wr_ff       <= `SFR_RST_IDX;
            rd_ff       <= `SFR_RST_IDX;
            lc_ff       <= `SFR_RST_IDX;
            full_ff     <= 1'b0;
            ptr_ff      <= `SFR_RST_PTR;
            bidx_ff     <= 3'h0;
            slot_ff     <= `SFR_RST_IDX;
            prox_q_ff   <= 1'b0;
            nfull_ff    <= 1'b0;
            news_ff     <= 1'b0;
        end else begin
            req_seen_ff <= req_s;
            ack_tgl_ff  <= ack_tgl_ff ^ go;
            rdata_ff    <= op_rd ? rbyte : rdata_ff;
            wr_ff       <= nxt_wr;
            rd_ff       <= nxt_rd;
            lc_ff       <= nxt_lc;
            full_ff     <= nxt_full;
            ptr_ff      <= nxt_ptr;
            bidx_ff     <= nxt_bidx;
            slot_ff     <= (rd07 && bidx_ff == 3'h0) ? rd_ff : slot_ff;
            prox_q_ff   <= prox_mode_i;
            nfull_ff    <= nxt_nfull;
            news_ff     <= nxt_news;
        end
    end

    // Sample storage carries no reset; indices say what is valid
    always_ff @(posedge clk_i) begin
        if (store) begin
            mem_ff[wr_ff] <= {ljust(smp_ch2_i, adc_res_i),
                              ljust(smp_ch1_i, adc_res_i)};
        end
    end

    assign near_full_o       = nfull_ff;
    assign new_sample_flag_o = news_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    ptr_hold_a:
    assert property (rd07 |=> ptr_ff == `SFR_ADDR_DATA)
        else $error("address moved on data register read");
    ptr_next_a:
    assert property ((op_rd || op_wr) && !ptr_stay
                     |=> ptr_ff == 8'($past(ptr_ff) + 8'h01))
        else $error("address did not advance");
    ptr_top_a:
    assert property ((op_rd || op_wr) && ptr_ff == `SFR_ADDR_TOP
                     |=> ptr_ff == `SFR_ADDR_TOP)
        else $error("address wrapped past top");
    rd_pop_a:
    assert property (pop && !prox_clr && !uv_s
                     |=> rd_ff == 5'($past(rd_ff) + 5'h01))
        else $error("read index not advanced on first byte");
    wr_push_a:
    assert property (store && !w_set |=> wr_ff == 5'($past(wr_ff) + 5'h01))
        else $error("write index not advanced on store");
    lost_sat_a:
    assert property (lost && !pop && !lc_set && lc_ff == `SFR_LOST_MAX
                     |=> lc_ff == `SFR_LOST_MAX)
        else $error("lost count left saturation");
    prox_empty_a:
    assert property (prox_clr && !uv_s |=> empty)
        else $error("proximity change left data");
    uv_clear_a:
    assert property (uv_s |=> wr_ff == 5'h00 && rd_ff == 5'h00)
        else $error("undervoltage did not clear indices");
    news_set_a:
    assert property (store |=> new_sample_flag_o [*1] ##1 1'b1)
        else $error("new sample flag missed");
    full_eq_a:
    assert property (full_ff |-> wr_ff == rd_ff)
        else $error("full with unequal indices");
    trip_hi_a:
    assert property (rd07 && bidx_ff == 3'h0 ##0 go[*1]
                     |=> rdata_ff[7:2] == 6'h00)
        else $error("unused triplet bits not zero");
    link_ans_a:
    assert property (@(posedge link_clk_i) disable iff (!nrst_i)
                     lk_take |-> ##[4:40] lk_done_ff)
        else $error("link request never answered");

    pop_c:  cover property (pop ##[1:20] pop);
    full_c: cover property (store ##1 full_ff);
    roll_c: cover property (roll);
endmodule

/* File: sfr_host_model.sv */
// Purpose: Host side of the byte register port, one request at a time
// Assumes: Strobes are taken on a rising link edge while busy is low
// Notes:   A hung request counts as a mismatch and closes the run
`timescale 1ns/1ps
module sfr_host_model (
    input  wire logic       link_clk_i,
    input  wire logic       lk_done_i,
    input  wire logic [7:0] lk_rdata_i,
    output logic            lk_addr_o,
    output logic            lk_wr_o,
    output logic            lk_rd_o,
    output logic      [7:0] lk_wdata_o
);
    initial begin
        lk_addr_o  = 1'b0;
        lk_wr_o    = 1'b0;
        lk_rd_o    = 1'b0;
        lk_wdata_o = 8'h00;
    end

    // ------------------------------------------------------------
    // One request, then wait for its done pulse
    // ------------------------------------------------------------
    task automatic op(input sfr_pkg::sfr_op_t k, input logic [7:0] d,
                      output logic [7:0] q);
        int n;
        @(negedge link_clk_i);
        lk_addr_o  = (k == sfr_pkg::SFR_OP_ADDR);
        lk_wr_o    = (k == sfr_pkg::SFR_OP_WR);
        lk_rd_o    = (k == sfr_pkg::SFR_OP_RD);
        lk_wdata_o = d;
        @(negedge link_clk_i);
        lk_addr_o  = 1'b0;
        lk_wr_o    = 1'b0;
        lk_rd_o    = 1'b0;
        // Released data must not look like a held value
        lk_wdata_o = ~d;
        // Done stands one link cycle; look mid-cycle, away from its edge
        for (n = 0; n < 100; n++) begin
            @(negedge link_clk_i);
            if (lk_done_i === 1'b1) begin
                break;
            end
        end
        q = lk_rdata_i;
        if (n == 100) begin
            $display("CHECK FAILED done expected 1 seen timeout");
            testbench.failures++;
            testbench.results();
        end
    endtask
endmodule

/* File: testbench.sv */
// Purpose: Register-level tests of the sample FIFO readout block
// Assumes: Samples enter on clk, register requests on the link clock
// Notes:   Sample memory is unreset, so reads of unknown slots go unchecked
`timescale 1ns/1ps
module testbench;
    logic        clk = 1'b0;
    logic        link_clk = 1'b0;
    logic        nrst, lk_addr, lk_wr, lk_rd, lk_done, lk_busy;
    logic [7:0]  lk_wdata, lk_rdata;
    logic        smp_valid, two_chan, prox_mode, prox_en, wrap, uvlo;
    logic [17:0] ch1, ch2, e;
    logic [1:0]  adc_res;
    logic [3:0]  nf_level;
    logic        near_full, new_flag;
    logic [7:0]  q;
    int          failures = 0;
    int          compares = 0;

    // ------------------------------------------------------------
    // Clocks and design
    // ------------------------------------------------------------
    always #25 clk = ~clk;
    initial begin
        #7;
        forever #16 link_clk = ~link_clk;
    end

    sfr_top i_dut (.clk_i(clk), .nrst_i(nrst), .link_clk_i(link_clk),
        .lk_addr_i(lk_addr), .lk_wr_i(lk_wr), .lk_rd_i(lk_rd),
        .lk_wdata_i(lk_wdata), .lk_rdata_o(lk_rdata),
        .lk_done_o(lk_done), .lk_busy_o(lk_busy),
        .smp_valid_i(smp_valid), .smp_ch1_i(ch1), .smp_ch2_i(ch2),
        .adc_res_i(adc_res), .two_chan_i(two_chan),
        .prox_mode_i(prox_mode), .proximity_irq_enable_i(prox_en),
        .wrap_on_full_i(wrap), .near_full_level_i(nf_level),
        .uvlo_i(uvlo), .near_full_o(near_full),
        .new_sample_flag_o(new_flag));

    sfr_host_model i_host (.link_clk_i(link_clk), .lk_done_i(lk_done),
        .lk_rdata_i(lk_rdata), .lk_addr_o(lk_addr), .lk_wr_o(lk_wr),
        .lk_rd_o(lk_rd), .lk_wdata_o(lk_wdata));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic results();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [7:0] x,
                       input logic [7:0] g);
        compares++;
        if (g !== x) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic setp(input logic [7:0] a);
        i_host.op(sfr_pkg::SFR_OP_ADDR, a, q);
    endtask

    task automatic wrb(input logic [7:0] d);
        i_host.op(sfr_pkg::SFR_OP_WR, d, q);
    endtask

    task automatic rdb(input string n, input logic [7:0] x);
        i_host.op(sfr_pkg::SFR_OP_RD, 8'h00, q);
        chk(n, x, q);
    endtask

    task automatic rdr(input logic [7:0] a, input logic [7:0] x);
        setp(a);
        rdb("register", x);
    endtask

    // Write position, lost count and read position in one burst
    task automatic clr();
        setp(8'h04);
        wrb(8'h00);
        wrb(8'h00);
        wrb(8'h00);
    endtask

    task automatic push(input int n);
        repeat (n) begin
            @(negedge clk);
            smp_valid = 1'b1;
            @(negedge clk);
            smp_valid = 1'b0;
        end
    endtask

    // Three bytes of one left-justified channel value
    task automatic trip(input logic [17:0] v);
        rdb("byte0", {6'h00, v[17:16]});
        rdb("byte1", v[15:8]);
        rdb("byte2", v[7:0]);
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        {nrst, smp_valid, two_chan, prox_mode, prox_en, wrap} = 6'h00;
        {uvlo, adc_res, nf_level} = 7'h02;
        ch1 = 18'h2d6b5;
        ch2 = 18'h12b4d;
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        setp(8'h04);
        rdb("widx", 8'h00);
        rdb("lost", 8'h00);
        rdb("ridx", 8'h00);
        for (int k = 0; k < 4; k++) begin
            adc_res = k[1:0];
            ch1 = 18'h2d6b5 >> k;
            push(1);
        end
        chk("new_flag", 8'h01, {7'h00, new_flag});
        rdr(8'h04, 8'h04);
        setp(8'hfe);
        // Busy must stand while the request is outstanding
        fork
            i_host.op(sfr_pkg::SFR_OP_RD, 8'h00, q);
            begin
                repeat (3) @(negedge link_clk);
                chk("busy", 8'h01, {7'h00, lk_busy});
            end
        join
        chk("busy", 8'h00, {7'h00, lk_busy});
        i_host.op(sfr_pkg::SFR_OP_RD, 8'h00, q);
        rdb("past_top", 8'h00);
        rdr(8'h00, 8'h40);
        setp(8'h07);
        rdb("first", 8'h02);
        rdr(8'h06, 8'h01);
        setp(8'h06);
        wrb(8'h00);
        setp(8'h07);
        for (int k = 0; k < 4; k++) begin
            e = (18'h2d6b5 >> k) << k;
            trip(e);
        end
        rdr(8'h00, 8'h00);
        rdr(8'h06, 8'h04);
        setp(8'h06);
        wrb(8'h03);
        setp(8'h07);
        trip(18'h2d6b0);
        setp(8'h05);
        wrb(8'h07);
        rdr(8'h05, 8'h07);
        clr();
        adc_res = 2'h0;
        two_chan = 1'b1;
        ch1 = 18'h35ac3;
        push(1);
        setp(8'h07);
        trip(18'h35ac3);
        trip(18'h12b4d);
        rdr(8'h06, 8'h01);
        two_chan = 1'b0;
        clr();
        push(29);
        chk("near_full", 8'h00, {7'h00, near_full});
        push(1);
        repeat (3) @(negedge clk);
        chk("near_full", 8'h01, {7'h00, near_full});
        push(5);
        rdr(8'h05, 8'h03);
        rdr(8'h04, 8'h00);
        setp(8'h07);
        i_host.op(sfr_pkg::SFR_OP_RD, 8'h00, q);
        setp(8'h05);
        rdb("lost", 8'h00);
        rdb("ridx", 8'h01);
        push(17);
        rdr(8'h05, 8'h0f);
        wrap = 1'b1;
        push(1);
        rdr(8'h04, 8'h02);
        rdr(8'h06, 8'h02);
        wrap = 1'b0;
        uvlo = 1'b1;
        repeat (5) @(negedge clk);
        uvlo = 1'b0;
        rdr(8'h04, 8'h00);
        rdr(8'h06, 8'h00);
        prox_en = 1'b1;
        for (int k = 0; k < 2; k++) begin
            push(2);
            prox_mode = ~prox_mode;
            repeat (4) @(negedge clk);
            rdr(8'h04, 8'(2 * k + 2));
            rdr(8'h06, 8'(2 * k + 2));
        end
        results();
    end
endmodule
